/* rsc_defs.svh */
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH
// Contract
// - normal/halt: reset-pin low pulses under three clocks are ignored, longer ones reset.
// - normal/halt: watchdog time-out resets when watchdog control selects reset mode.
// - debugger control reset bit written 1 resets all except the on-chip debugger.
// - supply below threshold holds reset; then hold until power-on count ends, longer with crystal.
// - leaving power-on reset, the core starts by fetching its reset vector.
// - stop mode: reset-pin low resets only if it passes the glitch filter width.
// - stop mode: debug pin low resets; cause shows power-on 1, others 0.
// - cause register is read-only; a read clears its upper four bits afterwards.
// - cause register shares its address with write-only watchdog control.
// - cause bits: 7 power-on, 6 stop, 5 watchdog, 4 external; bits 3..0 read 0.
// - after power-on reset the flags are power-on 1, others 0.
// - debugger-requested reset leaves flags power-on 1, others 0.
// - reset-pin reset in normal/halt sets only the external flag.
// - watchdog reset sets only the watchdog flag.
// - stop recovery by port pin sets only the stop flag.
// - stop recovery by watchdog sets stop and watchdog flags only.
// - power-on flag clears on any watchdog time-out or stop recovery.

// ==================================================
// bus map
`define RSC_ADDR_W 12
`define RSC_CAUSE_OFS 12'hFF0
`define RSC_DBGCTL_OFS 12'hFF4
`define RSC_STATUS_OFS 12'hFF8
`define RSC_DBG_RST_BIT 0
`define RSC_WDT_RSTMODE_BIT 0
`define RSC_WATCHDOG_CONTROL_RESET 8'h01

// ==================================================
// cause flag codes {por, stop, wdt, ext}
`define RSC_FLAGS_NONE 4'h0
`define RSC_FLAGS_POR 4'h8
`define RSC_FLAGS_STOP 4'h4
`define RSC_FLAGS_WDT 4'h2
`define RSC_FLAGS_SWDT 4'h6
`define RSC_FLAGS_EXT 4'h1
`define RSC_CAUSE_LOW 4'h0
`define RSC_PAD24 24'h000000
`define RSC_PAD31 31'h00000000
`define RSC_PAD28 28'h0000000

// ==================================================
// timing
`define RSC_CNT_W 16
`define RSC_FILT_W 8
`define RSC_NORMAL_MIN_LOW 8'h03
`define RSC_DBG_MIN_LOW 8'h01

// ==================================================
// filtered pins, index into the filter bank
`define RSC_PIN_N 2
`define RSC_PIN_EXT 0
`define RSC_PIN_DBG 1
`endif

/* rsc_pkg.sv */
package rsc_pkg;
  `include "rsc_defs.svh"

  typedef enum logic [1:0] {
    RSC_SUPPLY = 2'b00,
    RSC_HOLD = 2'b01,
    RSC_RUN = 2'b10
  } rsc_phase_t;

  typedef struct packed {
    logic por;
    logic stop;
    logic wdt;
    logic external_pin_flag;
  } rsc_flags_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`RSC_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } rsc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rsc_apb_rsp_t;

  typedef struct packed {
    logic supply_low;
    logic ext_pin_n;
    logic debug_pin_n;
    logic stop_mode;
    logic wdt_timeout;
    logic gpio_wake;
    logic xtal_en;
  } rsc_src_t;

  typedef struct packed {
    rsc_phase_t phase;
    logic [`RSC_CNT_W-1:0] cnt;
    rsc_flags_t flags;
    logic [7:0] wdt_ctl;
    logic dbg_req;
    logic sys_rst_n;
    logic ocd_rst_n;
    logic fetch_vec;
    logic stop_rec;
    logic wdt_wr;
    rsc_apb_rsp_t rsp;
  } rsc_state_t;
endpackage

/* rsc_low_filter.sv */
`timescale 1ns/1ps
`include "rsc_defs.svh"
// ==================================================
// low-pulse width filter behind a two-flop synchroniser
module rsc_low_filter (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic pin_n, // raw active-low pin
  input wire logic [`RSC_FILT_W-1:0] min_low, // low cycles needed
  output logic hit // pin held low long enough
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [`RSC_FILT_W-1:0] cnt;
    logic hit;
  } rsc_filt_state_t;

  rsc_filt_state_t q;
  rsc_filt_state_t n;

  // sync1 feeds sync2 only; the counter looks at sync2
  always_comb begin
    n = q;
    n.sync1 = pin_n;
    n.sync2 = q.sync1;
    if (q.sync2) begin
      n.cnt = '0;
      n.hit = 1'b0;
    end else begin
      if (q.cnt < min_low) begin
        n.cnt = q.cnt + 1'b1;
      end
      n.hit = ((q.cnt + 1'b1) >= min_low);
    end
  end

  // pin idles high, so the synchroniser resets high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{sync1: 1'b1, sync2: 1'b1, cnt: '0, hit: 1'b0};
    end else begin
      q <= n;
    end
  end

  assign hit = q.hit;
endmodule

/* rsc_reset_ctrl.sv */
`timescale 1ns/1ps
`include "rsc_defs.svh"
// ==================================================
// reset source control: sequencer, cause flags, APB slave
module rsc_reset_ctrl #(
  parameter logic [`RSC_CNT_W-1:0] POR_CYCLES = 16'h0400, // power-on hold
  parameter logic [`RSC_CNT_W-1:0] XTAL_CYCLES = 16'h1000, // crystal extension
  parameter logic [`RSC_FILT_W-1:0] STOP_MIN_LOW = 8'h0A // stop glitch filter
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input rsc_pkg::rsc_apb_req_t apb_req, // APB request
  output rsc_pkg::rsc_apb_rsp_t apb_rsp, // APB answer
  input rsc_pkg::rsc_src_t src, // reset and wake sources
  output logic sys_reset_n, // system reset, debugger excluded
  output logic ocd_reset_n, // debugger reset, power-on only
  output logic fetch_vector, // core fetches reset vector
  output logic stop_recover, // stop-mode recovery pulse
  output logic [7:0] watchdog_control, // watchdog control byte
  output logic watchdog_control_wr // watchdog control written
);
  import rsc_pkg::*;

  rsc_state_t q;
  rsc_state_t n;

  logic ext_hit;
  logic dbg_hit;
  logic [`RSC_PIN_N-1:0] pin_raw_n;
  logic [`RSC_PIN_N-1:0] pin_hit;
  logic [`RSC_PIN_N-1:0][`RSC_FILT_W-1:0] pin_min;
  logic [`RSC_FILT_W-1:0] ext_min;
  logic [`RSC_CNT_W-1:0] hold_len;
  logic setup;
  logic acc;
  logic hit_cause;
  logic hit_dbg;
  logic hit_status;
  logic mapped;
  logic in_stop;
  logic ev_dbgpin;
  logic ev_ocd;
  logic ev_ext;
  logic ev_wdt;
  logic ev_swdt;
  logic ev_gpio;
  logic hold_src;

  // ==================================================
  // pin filters
  // stop-mode filter width
  assign ext_min = src.stop_mode ? STOP_MIN_LOW : `RSC_NORMAL_MIN_LOW;

  // bank order: debug pin above reset pin, matching the index defines
  assign pin_raw_n = {src.debug_pin_n, src.ext_pin_n};
  assign pin_min = {`RSC_DBG_MIN_LOW, ext_min};

  // one synchroniser and width filter per active-low pin
  for (genvar g = 0; g < `RSC_PIN_N; g++) begin : g_pin_filt
    rsc_low_filter u_filt (
      .pclk(pclk),
      .presetn(presetn),
      .pin_n(pin_raw_n[g]),
      .min_low(pin_min[g]),
      .hit(pin_hit[g])
    );
  end

  assign ext_hit = pin_hit[`RSC_PIN_EXT];
  assign dbg_hit = pin_hit[`RSC_PIN_DBG];

  // ==================================================
  // event decode
  // hold length from parameters
  assign hold_len = src.xtal_en ? (POR_CYCLES + XTAL_CYCLES) : POR_CYCLES;

  assign in_stop = src.stop_mode;
  // debug pin only counts in stop mode
  assign ev_dbgpin = in_stop & dbg_hit;
  assign ev_ocd = q.dbg_req;
  assign ev_ext = ext_hit;
  // watchdog resets only in reset mode
  assign ev_wdt = ~in_stop & src.wdt_timeout & q.wdt_ctl[`RSC_WDT_RSTMODE_BIT];
  assign ev_swdt = in_stop & src.wdt_timeout;
  assign ev_gpio = in_stop & src.gpio_wake;

  // a held pin keeps restarting the hold count
  assign hold_src = ext_hit | ev_dbgpin;

  // ==================================================
  // bus decode
  assign setup = apb_req.psel & ~apb_req.penable & ~q.rsp.pready;
  assign acc = apb_req.psel & apb_req.penable & q.rsp.pready;
  // one address, read cause, write watchdog control
  assign hit_cause = (apb_req.paddr == `RSC_CAUSE_OFS);
  assign hit_dbg = (apb_req.paddr == `RSC_DBGCTL_OFS);
  assign hit_status = (apb_req.paddr == `RSC_STATUS_OFS);
  assign mapped = hit_cause | hit_dbg | hit_status;

  // ==================================================
  // next state
  always_comb begin
    n = q;
    n.fetch_vec = 1'b0;
    n.stop_rec = 1'b0;
    n.wdt_wr = 1'b0;
    n.rsp.pready = 1'b0;
    n.rsp.pslverr = 1'b0;

    // bus side effects land first so that events below win
    if (acc && mapped) begin
      if (apb_req.pwrite) begin
        if (hit_cause) begin
          n.wdt_ctl = apb_req.pwdata[7:0];
          n.wdt_wr = 1'b1;
        end
        if (hit_dbg && apb_req.pwdata[`RSC_DBG_RST_BIT]) begin
          n.dbg_req = 1'b1;
        end
      end else if (hit_cause) begin
        n.flags = `RSC_FLAGS_NONE;
      end
    end

    unique case (q.phase)
      RSC_SUPPLY: begin
        n.sys_rst_n = 1'b0;
        n.ocd_rst_n = 1'b0;
        n.cnt = '0;
        if (!src.supply_low) begin
          n.phase = RSC_HOLD;
        end
      end
      RSC_HOLD: begin
        n.sys_rst_n = 1'b0;
        n.dbg_req = 1'b0;
        if (src.supply_low) begin
          n.phase = RSC_SUPPLY;
          n.ocd_rst_n = 1'b0;
          n.flags = `RSC_FLAGS_POR;
          n.cnt = '0;
        end else if (hold_src) begin
          n.cnt = '0;
        end else if (q.cnt >= (hold_len - 1'b1)) begin
          // release core to its reset vector
          n.phase = RSC_RUN;
          n.sys_rst_n = 1'b1;
          n.ocd_rst_n = 1'b1;
          n.fetch_vec = 1'b1;
          n.cnt = '0;
        end else begin
          n.cnt = q.cnt + 1'b1;
        end
      end
      RSC_RUN: begin
        if (src.supply_low) begin
          n.phase = RSC_SUPPLY;
          n.sys_rst_n = 1'b0;
          n.ocd_rst_n = 1'b0;
          n.flags = `RSC_FLAGS_POR;
        end else if (ev_dbgpin) begin
          n.phase = RSC_HOLD;
          n.sys_rst_n = 1'b0;
          n.flags = `RSC_FLAGS_POR;
        end else if (ev_ocd) begin
          n.phase = RSC_HOLD;
          n.sys_rst_n = 1'b0;
          n.dbg_req = 1'b0;
          n.flags = `RSC_FLAGS_POR;
        end else if (ev_ext) begin
          n.phase = RSC_HOLD;
          n.sys_rst_n = 1'b0;
          n.flags = `RSC_FLAGS_EXT;
        end else if (ev_wdt) begin
          n.phase = RSC_HOLD;
          n.sys_rst_n = 1'b0;
          n.flags = `RSC_FLAGS_WDT;
        end else if (ev_swdt) begin
          n.flags = `RSC_FLAGS_SWDT;
          n.stop_rec = 1'b1;
        end else if (ev_gpio) begin
          n.flags = `RSC_FLAGS_STOP;
          n.stop_rec = 1'b1;
        end else if (src.wdt_timeout) begin
          n.flags.por = 1'b0;
        end
        n.cnt = '0;
      end
      default: begin
        n.phase = RSC_SUPPLY;
        n.sys_rst_n = 1'b0;
        n.ocd_rst_n = 1'b0;
        n.cnt = '0;
      end
    endcase

    // answer built in setup from next flags, so no event is missed
    if (setup) begin
      n.rsp.pready = 1'b1;
      n.rsp.pslverr = ~mapped;
      n.rsp.prdata = '0;
      if (!apb_req.pwrite) begin
        if (hit_cause) begin
          n.rsp.prdata = {`RSC_PAD24, n.flags, `RSC_CAUSE_LOW};
        end else if (hit_dbg) begin
          n.rsp.prdata = {`RSC_PAD31, n.dbg_req};
        end else if (hit_status) begin
          n.rsp.prdata = {`RSC_PAD28, n.phase, q.sys_rst_n, in_stop};
        end
      end
    end
  end

  // ==================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.phase <= RSC_SUPPLY;
      q.cnt <= '0;
      q.flags <= `RSC_FLAGS_POR;
      q.wdt_ctl <= `RSC_WATCHDOG_CONTROL_RESET;
      q.dbg_req <= 1'b0;
      q.sys_rst_n <= 1'b0;
      q.ocd_rst_n <= 1'b0;
      q.fetch_vec <= 1'b0;
      q.stop_rec <= 1'b0;
      q.wdt_wr <= 1'b0;
      q.rsp <= '0;
    end else begin
      q <= n;
    end
  end

  // ==================================================
  // outputs, all from flops
  assign apb_rsp = q.rsp;
  assign sys_reset_n = q.sys_rst_n;
  assign ocd_reset_n = q.ocd_rst_n;
  assign fetch_vector = q.fetch_vec;
  assign stop_recover = q.stop_rec;
  assign watchdog_control = q.wdt_ctl;
  assign watchdog_control_wr = q.wdt_wr;
endmodule

/* rsc_core_model.sv */
`timescale 1ns/1ps
// ==================================================
// core stand-in: takes the vector fetch strobe
module rsc_core_model (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic sys_reset_n, // system reset from controller
  input wire logic fetch_vector, // vector fetch strobe
  output logic [7:0] fetches, // fetches taken
  output logic bad_fetch // strobe seen while still in reset
);
  // vector fetch
  // a fetch under reset would run code on a half-reset core, so flag it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetches <= 8'h00;
      bad_fetch <= 1'b0;
    end else if (fetch_vector) begin
      fetches <= fetches + 8'h01;
      bad_fetch <= bad_fetch | ~sys_reset_n;
    end
  end
endmodule

/* rsc_reset_ctrl_chk.sv */
`timescale 1ns/1ps
`include "rsc_defs.svh"
// ==================================================
// port checker for the reset controller
module rsc_reset_ctrl_chk #(
  parameter logic [`RSC_CNT_W-1:0] POR_CYCLES = 16'h0400, // power-on hold
  parameter logic [`RSC_CNT_W-1:0] XTAL_CYCLES = 16'h1000, // crystal extension
  parameter logic [`RSC_FILT_W-1:0] STOP_MIN_LOW = 8'h0A // stop glitch filter
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input rsc_pkg::rsc_apb_req_t apb_req, // APB request
  input rsc_pkg::rsc_apb_rsp_t apb_rsp, // APB answer
  input rsc_pkg::rsc_src_t src, // reset sources
  input wire logic sys_reset_n, // system reset
  input wire logic ocd_reset_n, // debugger reset
  input wire logic fetch_vector, // vector fetch
  input wire logic stop_recover, // stop recovery
  input wire logic [7:0] watchdog_control, // watchdog control
  input wire logic watchdog_control_wr // watchdog write strobe
);
  import rsc_pkg::*;
  logic [15:0] lo_cnt;
  logic acc;
  logic cause;
  // cycles spent in reset, to bound the hold length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_cnt <= 16'h0000;
    end else begin
      lo_cnt <= sys_reset_n ? 16'h0000 : lo_cnt + 16'h0001;
    end
  end
  // completed access and its target
  assign acc = apb_req.psel && apb_req.penable && apb_rsp.pready;
  assign cause = apb_req.paddr == `RSC_CAUSE_OFS;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==================================================
  // assertions
  pready_one_a: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("no answer after setup");
  fetch_edge_a: assert property (fetch_vector |-> sys_reset_n && !$past(sys_reset_n))
    else $error("fetch not at reset end");
  cause_bits_a: assert property (acc && !apb_req.pwrite && cause |->
    apb_rsp.prdata[31:8] == 24'h000000 && apb_rsp.prdata[3:0] == 4'h0)
    else $error("cause reserved bits set");
  wdog_write_a: assert property (acc && apb_req.pwrite && cause |=>
    watchdog_control_wr && watchdog_control == $past(apb_req.pwdata[7:0]))
    else $error("watchdog control not written");
  unmapped_err_a: assert property (acc && !(apb_req.paddr inside {`RSC_CAUSE_OFS, `RSC_DBGCTL_OFS,
    `RSC_STATUS_OFS}) |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h00000000)
    else $error("unmapped access not refused");
  supply_hold_a: assert property (src.supply_low |=> !sys_reset_n && !ocd_reset_n)
    else $error("low supply not held in reset");
  ocd_keep_a: assert property (ocd_reset_n && !src.supply_low |=> ocd_reset_n)
    else $error("debugger reset without power-on");
  hold_len_a: assert property ($rose(sys_reset_n) |-> lo_cnt >= POR_CYCLES)
    else $error("reset hold too short");
  wdog_reset_a: assert property (!src.stop_mode && src.wdt_timeout && sys_reset_n &&
    watchdog_control[`RSC_WDT_RSTMODE_BIT] |=> ##[0:2] !sys_reset_n)
    else $error("watchdog reset missing");
  fetch_c: cover property (fetch_vector);
  stop_c: cover property (stop_recover);
  err_c: cover property (acc && apb_rsp.pslverr);
endmodule
bind rsc_reset_ctrl rsc_reset_ctrl_chk #(.POR_CYCLES(POR_CYCLES), .XTAL_CYCLES(XTAL_CYCLES),
  .STOP_MIN_LOW(STOP_MIN_LOW)) chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .src(src), .sys_reset_n(sys_reset_n), .ocd_reset_n(ocd_reset_n),
  .fetch_vector(fetch_vector), .stop_recover(stop_recover), .watchdog_control(watchdog_control),
  .watchdog_control_wr(watchdog_control_wr));

/* rsc_reset_ctrl_test.sv */
`timescale 1ns/1ps
`include "rsc_defs.svh"
module rsc_reset_ctrl_test;
  import rsc_pkg::*;
  localparam logic [15:0] POR = 16'h0010;
  localparam logic [15:0] XT = 16'h0008;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  rsc_apb_req_t req = '0;
  rsc_apb_rsp_t rsp;
  rsc_src_t src = 7'h30; // pins high, sources quiet
  logic srn, orn, fv, sr, wwr, bad, e;
  logic [7:0] wctl, nf;
  logic [31:0] r;
  int n_errors = 0;
  int check_count = 0;
  int n;
  always #5 pclk = ~pclk;
  // ==================================================
  // design and core model
  rsc_reset_ctrl #(.POR_CYCLES(POR), .XTAL_CYCLES(XT), .STOP_MIN_LOW(8'h0A)) DUT (.pclk(pclk),
    .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .src(src), .sys_reset_n(srn),
    .ocd_reset_n(orn), .fetch_vector(fv), .stop_recover(sr), .watchdog_control(wctl),
    .watchdog_control_wr(wwr));
  rsc_core_model core (.pclk(pclk), .presetn(presetn), .sys_reset_n(srn), .fetch_vector(fv),
    .fetches(nf), .bad_fetch(bad));
  // ==================================================
  // verdict, compares and bus tasks
  task give_verdict;
    if (n_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task fail;
    n_errors++;
    $display("BAD %0t wait ran out", $time);
    give_verdict;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, g, x);
    end
  endtask
  task ok(input logic c);
    chk({31'h0, c}, 32'h1);
  endtask
  // request stands until the rising edge that samples pready; data taken at that edge, then released
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    i = 0;
    do begin @(posedge pclk); i++; end while (rsp.pready !== 1'b1 && i < 20);
    if (rsp.pready !== 1'b1) fail;
    r = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  // wait for reset to start, then count its low cycles
  task wait_rel(output int c);
    int i;
    i = 0;
    c = 1;
    do begin @(negedge pclk); i++; end while (srn !== 1'b0 && i < 40);
    if (srn !== 1'b0) fail;
    while (srn !== 1'b1 && c < 300) begin @(negedge pclk); c++; end
    if (srn !== 1'b1) fail;
    @(posedge pclk);
  endtask
  task wait_sr;
    int i;
    i = 0;
    do begin @(negedge pclk); i++; end while (sr !== 1'b1 && i < 40);
    if (sr !== 1'b1) fail;
    repeat (3) @(posedge pclk);
  endtask
  task cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  // ==================================================
  // main sequence
  initial begin
    cyc(6);
    presetn <= 1'b1;
    wait_rel(n);
    ok(n >= POR);
    rd(`RSC_CAUSE_OFS, 32'h80);
    rd(`RSC_CAUSE_OFS, 32'h00);
    rd(12'hFFC, 32'h0);
    ok(e);
    apb(1'b1, `RSC_CAUSE_OFS, 32'h0);
    chk(wctl, 8'h00);
    ok(wwr);
    rd(`RSC_CAUSE_OFS, 32'h00);
    src.wdt_timeout <= 1'b1;
    cyc(1);
    src.wdt_timeout <= 1'b0;
    src.ext_pin_n <= 1'b0;
    cyc(2);
    src.ext_pin_n <= 1'b1;
    cyc(10);
    ok(srn);
    apb(1'b1, `RSC_CAUSE_OFS, 32'h1);
    src.ext_pin_n <= 1'b0;
    cyc(3);
    src.ext_pin_n <= 1'b1;
    wait_rel(n);
    rd(`RSC_CAUSE_OFS, 32'h10);
    src.wdt_timeout <= 1'b1;
    cyc(1);
    src.wdt_timeout <= 1'b0;
    wait_rel(n);
    rd(`RSC_CAUSE_OFS, 32'h20);
    apb(1'b1, `RSC_DBGCTL_OFS, 32'h1);
    wait_rel(n);
    ok(orn);
    rd(`RSC_CAUSE_OFS, 32'h80);
    chk(nf, 8'h04);
    apb(1'b1, `RSC_CAUSE_OFS, 32'h0);
    src.stop_mode <= 1'b1;
    src.ext_pin_n <= 1'b0;
    cyc(5);
    src.ext_pin_n <= 1'b1;
    cyc(12);
    ok(srn);
    src.ext_pin_n <= 1'b0;
    cyc(12);
    src.ext_pin_n <= 1'b1;
    wait_rel(n);
    rd(`RSC_CAUSE_OFS, 32'h10);
    repeat (2) begin
      src.debug_pin_n <= 1'b0;
      cyc(2);
      src.debug_pin_n <= 1'b1;
      wait_rel(n);
      rd(`RSC_CAUSE_OFS, 32'h80);
      src.debug_pin_n <= 1'b0;
      cyc(2);
      src.debug_pin_n <= 1'b1;
      wait_rel(n);
      src.gpio_wake <= 1'b1;
      cyc(1);
      src.gpio_wake <= 1'b0;
      wait_sr;
      rd(`RSC_CAUSE_OFS, 32'h40);
    end
    src.wdt_timeout <= 1'b1;
    cyc(1);
    src.wdt_timeout <= 1'b0;
    wait_sr;
    rd(`RSC_CAUSE_OFS, 32'h60);
    src.stop_mode <= 1'b0;
    src.xtal_en <= 1'b1;
    src.supply_low <= 1'b1;
    cyc(3);
    src.supply_low <= 1'b0;
    wait_rel(n);
    ok(n >= POR + XT);
    rd(`RSC_CAUSE_OFS, 32'h80);
    apb(1'b1, `RSC_DBGCTL_OFS, 32'h1);
    wait_rel(n);
    src.wdt_timeout <= 1'b1;
    cyc(1);
    src.wdt_timeout <= 1'b0;
    rd(`RSC_CAUSE_OFS, 32'h00);
    ok(srn);
    ok(!bad);
    give_verdict;
  end
endmodule
